// ==== verilog/gpw_pkg.sv ====
package gpw_pkg;
  // ****************************************************************
  // port geometry
  // ****************************************************************
  localparam int GPW_NPINS = 8;
  localparam logic [7:0] GPW_VALUE_RST = 8'h00;
  localparam logic [7:0] GPW_DIR_RST = 8'h00;
  localparam logic [7:0] GPW_OPT_RST = 8'h00;

  // ****************************************************************
  // edge sensitivity codes
  // ****************************************************************
  typedef enum logic [1:0] {
    GPW_SENSE_FALL_LOW = 2'h0,
    GPW_SENSE_RISE = 2'h1,
    GPW_SENSE_FALL = 2'h2,
    GPW_SENSE_BOTH = 2'h3
  } gpw_sense_t;
  localparam logic [1:0] GPW_SENSE_RST = 2'h0;
endpackage

// ==== verilog/gpw_sync.sv ====
`timescale 1ns/100ps
// three-stage input synchroniser; a change counts once stages two and
// three agree, so the first stage feeds only the second
module gpw_sync (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // data
  input wire logic [7:0] d,
  output logic [7:0] q
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] out;
  } gpw_sync_state_t;

  gpw_sync_state_t st;
  gpw_sync_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < 8; i++)
    begin
      if (st.s2[i] == st.s3[i])
      begin
        next_st.out[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q = st.out;
endmodule

// ==== verilog/gpw_port.sv ====
`timescale 1ns/100ps
module gpw_port
  import gpw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // cpu side: port value, direction, option
  input wire logic value_we,
  input wire logic [7:0] value_wdata,
  output logic [7:0] value_rdata,
  input wire logic dir_we,
  input wire logic [7:0] dir_wdata,
  output logic [7:0] dir,
  input wire logic opt_we,
  input wire logic [7:0] opt_wdata,
  output logic [7:0] opt,
  // cpu side: edge sense and interrupt
  input wire logic sense_we,
  input wire logic [1:0] sense_wdata,
  output logic [1:0] edge_sense_field,
  input wire logic vector_fetch,
  output logic ext_irq,
  // pins
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup,
  // peripheral alternate functions
  input wire logic [7:0] alt_out_en,
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_open_drain,
  input wire logic [7:0] alt_in_en,
  output logic [7:0] alt_in
);
  import gpw_pkg::*;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] opt;
    logic [1:0] sense;
    logic req_prev;
    logic pending;
    logic [7:0] rdata;
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
    logic [7:0] ain;
  } gpw_state_t;

  gpw_state_t st;
  gpw_state_t next_st;
  logic [7:0] pin_sync;
  logic [7:0] drv_out;
  logic [7:0] drv_oe;
  logic [7:0] rd_val;
  logic [7:0] ain_val;
  logic [7:0] irq_pins;
  logic req_low;
  logic evt;

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  gpw_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(pin_in),
    .q(pin_sync)
  );

  // ****************************************************************
  // per-pin drive and readback
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < GPW_NPINS; g++)
    begin : g_pin
      always_comb
      begin
        // alternate output wins over port programming
        if (alt_out_en[g])
        begin
          drv_out[g] = alt_open_drain[g] ? 1'b0 : alt_out[g];
          drv_oe[g] = alt_open_drain[g] ? !alt_out[g] : 1'b1;
        end
        else if (st.dir[g])
        begin
          // open-drain only pulls low; push-pull drives both
          drv_out[g] = st.opt[g] ? st.latch[g] : 1'b0;
          drv_oe[g] = st.opt[g] ? 1'b1 : !st.latch[g];
        end
        else
        begin
          drv_out[g] = 1'b0;
          drv_oe[g] = 1'b0;
        end
        // readback
        if (st.dir[g])
        begin
          rd_val[g] = st.latch[g];
        end
        else if (alt_out_en[g])
        begin
          rd_val[g] = alt_out[g];
        end
        else
        begin
          rd_val[g] = pin_sync[g];
        end
        // peripheral input sees latch when pin is an output
        ain_val[g] = (alt_in_en[g] && st.dir[g]) ? st.latch[g] : pin_sync[g];
        // input with interrupt
        irq_pins[g] = !st.dir[g] && st.opt[g];
      end
    end
  endgenerate

  // ****************************************************************
  // shared interrupt request
  // ****************************************************************
  always_comb
  begin
    // any enabled pin low asserts the group request
    req_low = |(irq_pins & ~pin_sync);
    // trigger chosen by the shared sense field
    case (gpw_sense_t'(st.sense))
      GPW_SENSE_FALL_LOW: evt = req_low;
      GPW_SENSE_FALL: evt = req_low && !st.req_prev;
      GPW_SENSE_RISE: evt = !req_low && st.req_prev;
      GPW_SENSE_BOTH: evt = req_low != st.req_prev;
      default: evt = 1'b0;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    next_st = st;
    if (value_we)
    begin
      next_st.latch = value_wdata;
    end
    if (dir_we)
    begin
      next_st.dir = dir_wdata;
    end
    if (opt_we)
    begin
      next_st.opt = opt_wdata;
    end
    next_st.req_prev = req_low;
    // clear by fetch or sense rewrite; a new event wins over a fetch only
    if (sense_we)
    begin
      next_st.sense = sense_wdata;
      next_st.pending = 1'b0;
    end
    else if (vector_fetch)
    begin
      next_st.pending = 1'b0;
    end
    // event from the old sense is dropped when the field is rewritten
    if (evt && !sense_we)
    begin
      next_st.pending = 1'b1;
    end
    next_st.rdata = rd_val;
    next_st.out = drv_out;
    next_st.oe = drv_oe;
    // pull-up in both input modes unless a peripheral drives
    next_st.pull = ~drv_oe & ~next_st.dir;
    next_st.ain = ain_val;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.latch <= GPW_VALUE_RST;
      st.dir <= GPW_DIR_RST;
      st.opt <= GPW_OPT_RST;
      st.sense <= GPW_SENSE_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign value_rdata = st.rdata;
  assign dir = st.dir;
  assign opt = st.opt;
  assign edge_sense_field = st.sense;
  assign ext_irq = st.pending;
  assign pin_out = st.out;
  assign pin_oe = st.oe;
  assign pin_pullup = st.pull;
  assign alt_in = st.ain;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_sense_clears: assert property (
    @(posedge clk) disable iff (!resetn)
    sense_we |=> !ext_irq)
    else $error("pending not cleared by sense write");
  a_fetch_clears: assert property (
    @(posedge clk) disable iff (!resetn)
    vector_fetch && !evt && !sense_we |=> !ext_irq)
    else $error("pending not cleared by fetch");
  a_event_sets: assert property (
    @(posedge clk) disable iff (!resetn)
    evt && !sense_we |=> ext_irq)
    else $error("event lost");
  a_level_mode: assert property (
    @(posedge clk) disable iff (!resetn)
    st.sense == 2'h0 && req_low && !sense_we |=> ext_irq)
    else $error("low level did not request");
  a_input_hiz: assert property (
    @(posedge clk) disable iff (!resetn)
    dir == 8'h00 && alt_out_en == 8'h00 |=> pin_oe == 8'h00)
    else $error("input pin driven");
  a_pushpull_drv: assert property (
    @(posedge clk) disable iff (!resetn)
    alt_out_en == 8'h00 && (dir & opt) == 8'hFF
    |=> pin_oe == 8'hFF && pin_out == $past(st.latch))
    else $error("push-pull drive wrong");
  a_output_read: assert property (
    @(posedge clk) disable iff (!resetn)
    dir == 8'hFF |=> value_rdata == $past(st.latch))
    else $error("output readback wrong");
  // checked per pin so that a single alternate pin is enough to trip it
  a_alt_read: assert property (
    @(posedge clk) disable iff (!resetn)
    1'b1 |=> ((value_rdata ^ $past(alt_out))
    & $past(alt_out_en & ~dir)) == 8'h00)
    else $error("alternate readback wrong");
  a_alt_in_latch: assert property (
    @(posedge clk) disable iff (!resetn)
    1'b1 |=> ((alt_in ^ $past(st.latch))
    & $past(alt_in_en & dir)) == 8'h00)
    else $error("peripheral input not latch");
  a_reset_vals: assert property (
    @(posedge clk)
    !resetn |=> dir == 8'h00 && opt == 8'h00)
    else $error("reset values wrong");
endmodule

// ==== test/gpw_pins.sv ====
`timescale 1ns/100ps
// external circuitry on the port pins
module gpw_pins (
  // clock
  input wire logic clk,
  // device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  // outside drivers
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] last;
  always_ff @(posedge clk)
    last <= pin_in;
  // a floating pin shows a level that keeps changing, never a steady guess
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pin_oe[i])
        pin_in[i] = pin_out[i];
      else if (ext_en[i])
        pin_in[i] = ext_val[i];
      else if (pin_pullup[i])
        pin_in[i] = 1'b1;
      else
        pin_in[i] = ~last[i];
    end
  end
endmodule

// ==== test/bidir_io_port_with_wakeup_irq_tb.sv ====
`timescale 1ns/100ps
module bidir_io_port_with_wakeup_irq_tb;
  import gpw_pkg::*;
  logic clk, resetn, value_we, dir_we, opt_we, sense_we, vector_fetch;
  logic [7:0] value_wdata, dir_wdata, opt_wdata, value_rdata, dir, opt;
  logic [1:0] sense_wdata, edge_sense_field;
  logic ext_irq;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val;
  logic [7:0] alt_out_en, alt_out, alt_open_drain, alt_in_en, alt_in;
  int failures, n_compared, cyc;
  logic [1:0] c;

  gpw_port dut_u (.clk(clk), .resetn(resetn), .value_we(value_we),
    .value_wdata(value_wdata), .value_rdata(value_rdata),
    .dir_we(dir_we), .dir_wdata(dir_wdata), .dir(dir), .opt_we(opt_we),
    .opt_wdata(opt_wdata), .opt(opt), .sense_we(sense_we),
    .sense_wdata(sense_wdata), .edge_sense_field(edge_sense_field),
    .vector_fetch(vector_fetch), .ext_irq(ext_irq), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .alt_out_en(alt_out_en), .alt_out(alt_out),
    .alt_open_drain(alt_open_drain), .alt_in_en(alt_in_en),
    .alt_in(alt_in));
  gpw_pins pins_u (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .pin_in(pin_in));

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    @(negedge clk);
    value_wdata = d;
    dir_wdata = d;
    opt_wdata = d;
    sense_wdata = d[1:0];
    value_we = (k == 0);
    dir_we = (k == 1);
    opt_we = (k == 2);
    sense_we = (k == 3);
    @(negedge clk);
    {value_we, dir_we, opt_we, sense_we} = 4'h0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic fetch();
    @(negedge clk);
    vector_fetch = 1'b1;
    @(negedge clk);
    vector_fetch = 1'b0;
  endtask
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      wrap_up();
    end
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {resetn, value_we, dir_we, opt_we, sense_we, vector_fetch} = 6'h0;
    {value_wdata, dir_wdata, opt_wdata, ext_en, ext_val} = 40'h0;
    {alt_out_en, alt_out, alt_open_drain, alt_in_en} = 32'h0;
    sense_wdata = 2'h0;
    idle(2);
    resetn = 1'b1;
    idle(3);
    chk(dir, GPW_DIR_RST);
    chk(opt, GPW_OPT_RST);
    chk({6'h0, edge_sense_field}, 8'h00);
    chk({7'h0, ext_irq}, 8'h00);
    chk(pin_oe, 8'h00);
    chk(pin_pullup, 8'hFF);
    ext_en = 8'hFF;
    ext_val = 8'h5A;
    wr(0, 8'hA5); // latch loaded before output mode
    idle(8);
    chk(value_rdata, 8'h5A);
    chk(pin_oe, 8'h00);
    ext_en = 8'h00;
    wr(2, 8'hFF);
    wr(1, 8'hFF);
    idle(3);
    chk(dir, 8'hFF);
    chk(pin_out, 8'hA5);
    chk(pin_oe, 8'hFF);
    chk(value_rdata, 8'hA5);
    wr(2, 8'h0F);
    idle(3);
    chk(pin_oe, 8'h5F);
    chk(pin_out, 8'h05);
    wr(1, 8'h0F);
    idle(8);
    chk(pin_oe, 8'h0F);
    chk(pin_pullup, 8'hF0);
    chk(value_rdata, 8'hF5);
    // alternate functions, never on an interrupt pin
    wr(1, 8'h00);
    wr(2, 8'h00); // interrupt option off before any alternate
    alt_out_en = 8'h01;
    alt_out = 8'h01;
    idle(8);
    chk(pin_oe & 8'h01, 8'h01);
    chk(pin_out & 8'h01, 8'h01);
    chk(value_rdata & 8'h01, 8'h01);
    alt_out = 8'h00;
    idle(8);
    chk(value_rdata & 8'h01, 8'h00);
    alt_open_drain = 8'h01;
    alt_out = 8'h01;
    idle(3);
    chk(pin_oe & 8'h01, 8'h00);
    alt_out_en = 8'h00;
    wr(0, 8'h02); // whole-byte write, no bit set/clear
    wr(1, 8'h02);
    alt_in_en = 8'h06;
    ext_en = 8'h04;
    ext_val = 8'h04;
    idle(8);
    chk(alt_in & 8'h06, 8'h06);
    chk(value_rdata & 8'h04, 8'h04);
    ext_val = 8'h00;
    idle(8);
    chk(alt_in & 8'h06, 8'h02);
    // pin interrupts
    alt_in_en = 8'h00;
    wr(1, 8'h00);
    wr(2, 8'h01);
    ext_en = 8'hFF;
    ext_val = 8'hFF;
    idle(8);
    for (int i = 0; i < 4; i++)
    begin
      c = i[1:0];
      wr(3, {6'h0, c});
      idle(1);
      chk({7'h0, ext_irq}, 8'h00);
      chk({6'h0, edge_sense_field}, {6'h0, c});
      ext_val = 8'hFE;
      idle(8);
      chk({7'h0, ext_irq}, {7'h0, c != GPW_SENSE_RISE});
      fetch();
      idle(3);
      chk({7'h0, ext_irq}, {7'h0, c == GPW_SENSE_FALL_LOW});
      ext_val = 8'hFF;
      idle(8);
      chk({7'h0, ext_irq}, {7'h0, c != GPW_SENSE_FALL});
    end
    wr(3, 8'h02);
    idle(1);
    chk({7'h0, ext_irq}, 8'h00);
    wr(2, 8'h03);
    ext_val = 8'hFD;
    idle(8);
    chk({7'h0, ext_irq}, 8'h01);
    wr(3, 8'h02);
    ext_val = 8'hFC;
    idle(8);
    chk({7'h0, ext_irq}, 8'h00);
    wrap_up();
  end
endmodule
